// [eeprom_opt_pkg.sv]
// Constants, field layouts and carrier types for the option registers
// and the nonvolatile program/erase control.
// Assumes the register block sits at its reset position ($10xx).
//
// Operation
// RQ1 - Once-only option fields: one write in first 64 cycles, normal modes only.
// RQ2 - Analog power-up bit 7: 0 powers converter down, 1 powers it up.
// RQ3 - Pump clock select: 0 bus clock, 1 internal RC clock to pumps.
// RQ4 - Software selects RC pump clock when bus clock is 1 MHz or less.
// RQ5 - Interrupt sense: 0 low level, 1 falling edge only.
// RQ6 - Stop exit: about four cycles without delay bit, 4000 cycles with it.
// RQ7 - Monitor follows its enable until forced bit set; forced holds until reset.
// RQ8 - Software clears monitor enable around stop; forced bit stays 0 then.
// RQ9 - Options-two bits 7 and 6 make ports G and C open-drain.
// RQ10 - Quad clock pin low when disabled, buffered crystal clock when enabled.
// RQ11 - Options-two bits 4:0 and protect bits 7:5 read zero.
// RQ12 - Protect bits clear only in first 64 cycles; set bits hold till reset. Code also clears them at any time in special mode.
// RQ13 - Configuration-protect bit blocks program/erase of configuration byte.
// RQ14 - Four protect bits guard 32, 64, 128, 288 byte regions in order.
// RQ15 - With latch clear the array reads as ROM; protection ignores reads.
// RQ16 - Setting latch and high voltage together first sets neither.
// RQ17 - Array writes during high voltage are ignored; operation continues.
// RQ18 - No array write between latch and high voltage means no operation.
// RQ19 - Program operations ignore row and byte size bits.
// RQ20 - Software erase sequence: set bits, write target, high voltage, 10 ms, clear.
// RQ21 - Software program sequence: latch, store, high voltage, 10 ms, clear.
// RQ22 - Software erases before programming; programming only clears bits.
// RQ23 - Bulk erase at configuration byte erases it and array; array bulk spares it.
// RQ24 - Single-chip: array at top page; else page and presence from configuration.
// RQ25 - Control register: byte 4, row 3, erase 2, latch 1, high voltage 0.
// RQ26 - Size: both clear bulk, row alone 16-byte row, byte set single byte.
// RQ27 - High voltage written only while latch set; latch captures address and data.
// RQ28 - Erased bytes read all ones; programming clears bits only.
// RQ29 - Two-bit watchdog rate passes unchanged to the watchdog.
package eeprom_opt_pkg;
    localparam logic [15:0] ADDR_BLOCK_PROTECT = 16'h1035;
    localparam logic [15:0] ADDR_OPTIONS_TWO = 16'h1038;
    localparam logic [15:0] ADDR_OPTIONS = 16'h1039;
    localparam logic [15:0] ADDR_PROGRAM_CONTROL = 16'h103B;
    localparam logic [15:0] ADDR_CONFIG = 16'h103F;

    localparam int OPT_ANALOG_POWER_UP = 7;
    localparam int OPT_PUMP_CLOCK_SELECT = 6;
    localparam int OPT_INTERRUPT_SENSE_EDGE = 5;
    localparam int OPT_DLY = 4;
    localparam int OPT_CME = 3;
    localparam int OPT_FORCED_MONITOR = 2;
    localparam int OPT_CR_HI = 1;
    localparam int OPT_CR_LO = 0;
    localparam logic [7:0] OPT_ONCE_MASK = 8'h37;
    localparam logic [7:0] OPT_RESET = 8'h00;

    localparam int SYSTEM_OPTIONS_TWO_PORT_G_OPEN_DRAIN = 7;
    localparam int SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN = 6;
    localparam int SYSTEM_OPTIONS_TWO_QUAD_CLOCK_OUTPUT_ENABLE = 5;
    localparam logic [7:0] SYSTEM_OPTIONS_TWO_MASK = 8'hE0;
    localparam logic [7:0] SYSTEM_OPTIONS_TWO_RESET = 8'h00;

    localparam int BP_CONFIGURATION_PROTECT = 4;
    localparam logic [7:0] BP_MASK = 8'h1F;
    localparam logic [7:0] BP_RESET = 8'h1F;

    localparam int PP_BYTE = 4;
    localparam int PP_ROW = 3;
    localparam int PP_ERASE = 2;
    localparam int PP_LAT = 1;
    localparam int PP_HV = 0;
    localparam logic [7:0] PP_MASK = 8'hDF;
    localparam logic [7:0] PP_RESET = 8'h00;

    localparam int CFG_EEPROM_PRESENT = 0;
    localparam logic [7:0] CFG_ONES = 8'h0A;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    localparam logic [2:0] EE_LOCAL_TOP = 3'h7;
    localparam logic [3:0] SINGLE_CHIP_PAGE = 4'hF;
    localparam logic [8:0] REGION1_BASE = 9'h020;
    localparam logic [8:0] REGION2_BASE = 9'h060;
    localparam logic [8:0] REGION3_BASE = 9'h0E0;
    localparam int EE_BYTES = 512;

    localparam logic [6:0] WINDOW_CYCLES = 7'h40;
    localparam logic [11:0] STOP_DELAY_LONG = 12'hFA0;
    localparam logic [11:0] STOP_DELAY_SHORT = 12'h004;

    localparam int SYNC_IRQ = 0;
    localparam int SYNC_WAKE = 1;
    localparam int SYNC_XTAL = 2;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_STOPPED = 3'b010,
        ST_WAKE = 3'b100
    } stop_state_e;

    typedef struct packed {
        logic erase;
        logic byte_size;
        logic row_size;
        logic to_config;
        logic [8:0] index;
        logic [7:0] data;
    } nv_op_s;

    typedef struct packed {
        logic analog_power_up;
        logic pump_clock_select;
        logic interrupt_sense_edge;
        logic stop_delay_enable;
        logic clock_monitor_on;
        logic [1:0] watchdog_rate;
        logic port_g_open_drain;
        logic port_c_open_drain;
        logic [3:0] eeprom_page_select;
        logic eeprom_present;
        logic pump_high_voltage;
    } sys_out_s;
endpackage

// [eeprom_cells.sv]
// Nonvolatile cell array: 512 data bytes plus the configuration byte.
// Assumes one commit pulse per finished high-voltage period.
`timescale 1ns/10ps
`default_nettype none
module eeprom_cells (
    input wire logic clk, // Bus clock
    input wire logic commit, // Apply op this cycle
    input wire eeprom_opt_pkg::nv_op_s op, // Operation to apply
    input wire logic [8:0] rd_index, // Array read index
    output logic [7:0] rd_data, // Array read data
    output logic [7:0] config_cell // Configuration byte cell
);
    // No reset: contents survive reset like real cells
    logic [7:0] cell_ff [eeprom_opt_pkg::EE_BYTES];
    logic [7:0] nxt_cell [eeprom_opt_pkg::EE_BYTES];
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic bulk;

    always_comb
    begin
        bulk = op.erase && !op.byte_size && !op.row_size; // [RQ26]
        nxt_cfg = cfg_ff;
        if (commit && op.to_config)
        begin
            nxt_cfg = op.erase ? eeprom_opt_pkg::ERASED_BYTE : (cfg_ff & op.data); // [RQ28]
        end
        for (int i = 0; i < eeprom_opt_pkg::EE_BYTES; i++)
        begin
            nxt_cell[i] = cell_ff[i];
            if (commit)
            begin
                if (bulk)
                begin
                    nxt_cell[i] = eeprom_opt_pkg::ERASED_BYTE; // [RQ23]
                end
                else if (!op.to_config && op.erase && op.byte_size)
                begin
                    if (9'(i) == op.index)
                    begin
                        nxt_cell[i] = eeprom_opt_pkg::ERASED_BYTE; // [RQ26]
                    end
                end
                else if (!op.to_config && op.erase)
                begin
                    if (9'(i) >> 4 == op.index >> 4)
                    begin
                        nxt_cell[i] = eeprom_opt_pkg::ERASED_BYTE; // [RQ26]
                    end
                end
                else if (!op.to_config && 9'(i) == op.index)
                begin
                    nxt_cell[i] = cell_ff[i] & op.data; // [RQ19] [RQ28]
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        cfg_ff <= nxt_cfg;
        cell_ff <= nxt_cell;
    end

    assign rd_data = cell_ff[rd_index];
    assign config_cell = cfg_ff;
endmodule // eeprom_cells
`default_nettype wire

// [eeprom_option_ctrl.sv]
// Option registers, block protect and program/erase control with its
// interlocks, stop-exit delay, interrupt sense and quad clock pin.
// Assumes a CPU-style bus: one-cycle write strobe, read data a cycle later.
`timescale 1ns/10ps
`default_nettype none
module eeprom_option_ctrl (
    input wire logic clk, // Bus clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [15:0] bus_addr, // Bus address
    input wire logic [7:0] bus_wdata, // Bus write data
    input wire logic bus_wr, // Write strobe, one cycle
    input wire logic bus_rd, // Read strobe, one cycle
    input wire logic special_mode, // Special test or bootstrap mode
    input wire logic single_chip_mode, // Single-chip or bootstrap mode
    input wire logic irq_pin_n, // External interrupt pin
    input wire logic irq_ack, // Edge interrupt acknowledge
    input wire logic stop_enter, // CPU executes stop
    input wire logic wake_pin, // Wake-up event from pin
    input wire logic xtal_clk, // Crystal clock as sampled level
    output logic [7:0] rdata_ff, // Read data
    output logic rd_valid_ff, // Read data valid pulse
    output var eeprom_opt_pkg::sys_out_s sys_ff, // Option outputs
    output logic irq_request_ff, // Interrupt request to CPU
    output logic running_ff, // CPU clocks running
    output logic quad_clock_output_pin_ff // Quad clock pin
);
    logic [2:0] sync1_ff, sync2_ff;
    logic irq_prev_ff, nxt_irq_prev, irq_pend_ff, nxt_irq_pend, nxt_irq_req;
    logic [6:0] cyc_ff, nxt_cyc;
    logic window_open;
    logic [7:0] opt_ff, nxt_opt, system_options_two_ff, nxt_system_options_two, bp_ff, nxt_bp, pp_ff, nxt_pp;
    logic [7:0] cfg_ff, nxt_cfg;
    logic opt_once_ff, nxt_once, armed_ff, nxt_armed, running_op_ff, nxt_running_op;
    logic commit_ff, nxt_commit;
    eeprom_opt_pkg::nv_op_s op_ff, nxt_op;
    eeprom_opt_pkg::sys_out_s nxt_sys;
    logic [7:0] nxt_rdata, cell_rd, config_cell;
    logic [3:0] page;
    logic wr_opt, wr_system_options_two, wr_bp, wr_pp, ee_wr, hit_rd;
    eeprom_opt_pkg::stop_state_e st_ff, nxt_st;
    logic [11:0] dly_cnt_ff, nxt_dly_cnt;
    logic nxt_running, nxt_quad;

    function automatic logic hit_array(input logic [15:0] a, input logic [3:0] pg);
        hit_array = a[15:12] == pg && a[11:9] == eeprom_opt_pkg::EE_LOCAL_TOP;
    endfunction

    function automatic logic op_blocked(input eeprom_opt_pkg::nv_op_s o,
        input logic [7:0] pp, input logic [7:0] bp);
        logic bulk;
        logic region;
        bulk = pp[eeprom_opt_pkg::PP_ERASE] && !pp[eeprom_opt_pkg::PP_BYTE]
            && !pp[eeprom_opt_pkg::PP_ROW];
        if (o.index < eeprom_opt_pkg::REGION1_BASE)
            region = bp[0];
        else if (o.index < eeprom_opt_pkg::REGION2_BASE)
            region = bp[1];
        else if (o.index < eeprom_opt_pkg::REGION3_BASE)
            region = bp[2];
        else
            region = bp[3]; // [RQ14]
        if (o.to_config)
            op_blocked = bp[eeprom_opt_pkg::BP_CONFIGURATION_PROTECT] || (bulk && |bp[3:0]); // [RQ13]
        else
            op_blocked = bulk ? |bp[3:0] : region; // [RQ14]
    endfunction

    eeprom_cells u_cells (
        .clk(clk),
        .commit(commit_ff),
        .op(op_ff),
        .rd_index(bus_addr[8:0]),
        .rd_data(cell_rd),
        .config_cell(config_cell)
    );

    // Decode and register file
    always_comb
    begin
        page = single_chip_mode ? eeprom_opt_pkg::SINGLE_CHIP_PAGE : cfg_ff[7:4]; // [RQ24]
        window_open = cyc_ff < eeprom_opt_pkg::WINDOW_CYCLES;
        wr_opt = bus_wr && bus_addr == eeprom_opt_pkg::ADDR_OPTIONS;
        wr_system_options_two = bus_wr && bus_addr == eeprom_opt_pkg::ADDR_OPTIONS_TWO;
        wr_bp = bus_wr && bus_addr == eeprom_opt_pkg::ADDR_BLOCK_PROTECT;
        wr_pp = bus_wr && bus_addr == eeprom_opt_pkg::ADDR_PROGRAM_CONTROL;
        hit_rd = hit_array(bus_addr, page) && sys_ff.eeprom_present;
        ee_wr = bus_wr && (hit_rd || bus_addr == eeprom_opt_pkg::ADDR_CONFIG);
        nxt_cyc = window_open ? cyc_ff + 7'h01 : cyc_ff;
        nxt_cfg = rst_n ? cfg_ff : config_cell;
        nxt_opt = opt_ff;
        nxt_once = opt_once_ff;
        if (wr_opt)
        begin
            nxt_opt = (opt_ff & eeprom_opt_pkg::OPT_ONCE_MASK)
                | (bus_wdata & ~eeprom_opt_pkg::OPT_ONCE_MASK);
            if (special_mode || (window_open && !opt_once_ff))
            begin
                nxt_opt = bus_wdata; // [RQ1]
                nxt_once = !special_mode;
            end
        end
        nxt_opt[eeprom_opt_pkg::OPT_FORCED_MONITOR] = nxt_opt[eeprom_opt_pkg::OPT_FORCED_MONITOR]
            | opt_ff[eeprom_opt_pkg::OPT_FORCED_MONITOR]; // [RQ7]
        nxt_system_options_two = wr_system_options_two ? (bus_wdata & eeprom_opt_pkg::SYSTEM_OPTIONS_TWO_MASK) : system_options_two_ff; // [RQ11]
        nxt_bp = bp_ff;
        if (wr_bp)
        begin
            nxt_bp = (special_mode || window_open) ? (bus_wdata & eeprom_opt_pkg::BP_MASK)
                : (bp_ff | (bus_wdata & eeprom_opt_pkg::BP_MASK)); // [RQ12] [RQ11]
        end
        nxt_pp = pp_ff;
        if (wr_pp)
        begin
            nxt_pp = bus_wdata & eeprom_opt_pkg::PP_MASK; // [RQ25]
            nxt_pp[eeprom_opt_pkg::PP_HV] = pp_ff[eeprom_opt_pkg::PP_LAT]
                && bus_wdata[eeprom_opt_pkg::PP_LAT] && bus_wdata[eeprom_opt_pkg::PP_HV]; // [RQ27]
            if (!pp_ff[eeprom_opt_pkg::PP_LAT] && bus_wdata[eeprom_opt_pkg::PP_HV])
            begin
                nxt_pp[eeprom_opt_pkg::PP_LAT] = 1'b0; // [RQ16]
            end
        end
    end

    // Latch, arm and commit sequencing
    always_comb
    begin
        nxt_op = op_ff;
        nxt_armed = armed_ff;
        nxt_running_op = running_op_ff;
        nxt_commit = 1'b0;
        // A write during high voltage never touches the captured op
        if (ee_wr && pp_ff[eeprom_opt_pkg::PP_LAT] && !pp_ff[eeprom_opt_pkg::PP_HV]) // [RQ17]
        begin
            nxt_op.index = bus_addr[8:0]; // [RQ27]
            nxt_op.data = bus_wdata;
            nxt_op.to_config = bus_addr == eeprom_opt_pkg::ADDR_CONFIG;
            nxt_armed = 1'b1;
        end
        if (!pp_ff[eeprom_opt_pkg::PP_HV] && nxt_pp[eeprom_opt_pkg::PP_HV])
        begin
            nxt_op.erase = nxt_pp[eeprom_opt_pkg::PP_ERASE];
            nxt_op.byte_size = nxt_pp[eeprom_opt_pkg::PP_BYTE];
            nxt_op.row_size = nxt_pp[eeprom_opt_pkg::PP_ROW];
            nxt_running_op = armed_ff && !op_blocked(op_ff, nxt_pp, bp_ff); // [RQ18]
        end
        if (pp_ff[eeprom_opt_pkg::PP_HV] && !nxt_pp[eeprom_opt_pkg::PP_HV])
        begin
            nxt_commit = running_op_ff;
            nxt_running_op = 1'b0;
        end
        if (!nxt_pp[eeprom_opt_pkg::PP_LAT])
        begin
            nxt_armed = 1'b0;
        end
    end

    // Read path, outputs, interrupt, stop exit and quad clock
    always_comb
    begin
        case (bus_addr)
            eeprom_opt_pkg::ADDR_BLOCK_PROTECT: nxt_rdata = bp_ff & eeprom_opt_pkg::BP_MASK;
            eeprom_opt_pkg::ADDR_OPTIONS_TWO: nxt_rdata = system_options_two_ff;
            eeprom_opt_pkg::ADDR_OPTIONS: nxt_rdata = opt_ff;
            eeprom_opt_pkg::ADDR_PROGRAM_CONTROL: nxt_rdata = pp_ff;
            eeprom_opt_pkg::ADDR_CONFIG: nxt_rdata = cfg_ff | eeprom_opt_pkg::CFG_ONES;
            default: nxt_rdata = hit_rd ? cell_rd : 8'h00; // [RQ15]
        endcase
        if (!bus_rd)
            nxt_rdata = rdata_ff;
        nxt_sys.analog_power_up = opt_ff[eeprom_opt_pkg::OPT_ANALOG_POWER_UP]; // [RQ2]
        nxt_sys.pump_clock_select = opt_ff[eeprom_opt_pkg::OPT_PUMP_CLOCK_SELECT]; // [RQ3]
        nxt_sys.interrupt_sense_edge = opt_ff[eeprom_opt_pkg::OPT_INTERRUPT_SENSE_EDGE];
        nxt_sys.stop_delay_enable = opt_ff[eeprom_opt_pkg::OPT_DLY];
        nxt_sys.clock_monitor_on = opt_ff[eeprom_opt_pkg::OPT_CME]
            | opt_ff[eeprom_opt_pkg::OPT_FORCED_MONITOR]; // [RQ7]
        nxt_sys.watchdog_rate =
            opt_ff[eeprom_opt_pkg::OPT_CR_HI:eeprom_opt_pkg::OPT_CR_LO]; // [RQ29]
        nxt_sys.port_g_open_drain = system_options_two_ff[eeprom_opt_pkg::SYSTEM_OPTIONS_TWO_PORT_G_OPEN_DRAIN]; // [RQ9]
        nxt_sys.port_c_open_drain = system_options_two_ff[eeprom_opt_pkg::SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN]; // [RQ9]
        nxt_sys.eeprom_page_select = page; // [RQ24]
        nxt_sys.eeprom_present = single_chip_mode || cfg_ff[eeprom_opt_pkg::CFG_EEPROM_PRESENT];
        nxt_sys.pump_high_voltage = running_op_ff;
        nxt_irq_prev = sync2_ff[eeprom_opt_pkg::SYNC_IRQ];
        nxt_irq_pend = (irq_pend_ff && !irq_ack)
            || (irq_prev_ff && !sync2_ff[eeprom_opt_pkg::SYNC_IRQ]);
        nxt_irq_req = opt_ff[eeprom_opt_pkg::OPT_INTERRUPT_SENSE_EDGE] ? nxt_irq_pend
            : !sync2_ff[eeprom_opt_pkg::SYNC_IRQ]; // [RQ5]
        nxt_st = st_ff;
        nxt_dly_cnt = dly_cnt_ff;
        nxt_running = running_ff;
        case (st_ff)
            eeprom_opt_pkg::ST_RUN:
            begin
                if (stop_enter)
                begin
                    nxt_st = eeprom_opt_pkg::ST_STOPPED;
                    nxt_running = 1'b0;
                end
            end
            eeprom_opt_pkg::ST_STOPPED:
            begin
                if (sync2_ff[eeprom_opt_pkg::SYNC_WAKE])
                begin
                    nxt_st = eeprom_opt_pkg::ST_WAKE;
                    nxt_dly_cnt = (opt_ff[eeprom_opt_pkg::OPT_DLY]
                        ? eeprom_opt_pkg::STOP_DELAY_LONG
                        : eeprom_opt_pkg::STOP_DELAY_SHORT) - 12'h001; // [RQ6]
                end
            end
            eeprom_opt_pkg::ST_WAKE:
            begin
                if (dly_cnt_ff == 12'h000)
                begin
                    nxt_st = eeprom_opt_pkg::ST_RUN;
                    nxt_running = 1'b1;
                end
                else
                    nxt_dly_cnt = dly_cnt_ff - 12'h001;
            end
            default: nxt_st = eeprom_opt_pkg::ST_RUN;
        endcase
        // Sampled crystal level: only faithful for slow crystals in this model
        nxt_quad = system_options_two_ff[eeprom_opt_pkg::SYSTEM_OPTIONS_TWO_QUAD_CLOCK_OUTPUT_ENABLE]
            && sync2_ff[eeprom_opt_pkg::SYNC_XTAL]; // [RQ10]
    end

    always_ff @(posedge clk)
    begin
        sync1_ff <= {xtal_clk, wake_pin, irq_pin_n};
        sync2_ff <= sync1_ff;
        cfg_ff <= nxt_cfg;
        if (!rst_n)
        begin
            cyc_ff <= 7'h00;
            opt_ff <= eeprom_opt_pkg::OPT_RESET;
            system_options_two_ff <= eeprom_opt_pkg::SYSTEM_OPTIONS_TWO_RESET;
            bp_ff <= eeprom_opt_pkg::BP_RESET;
            pp_ff <= eeprom_opt_pkg::PP_RESET;
            opt_once_ff <= 1'b0;
            armed_ff <= 1'b0;
            running_op_ff <= 1'b0;
            commit_ff <= 1'b0;
            op_ff <= '0;
            rdata_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
            sys_ff <= '0;
            irq_prev_ff <= 1'b1;
            irq_pend_ff <= 1'b0;
            irq_request_ff <= 1'b0;
            st_ff <= eeprom_opt_pkg::ST_RUN;
            dly_cnt_ff <= 12'h000;
            running_ff <= 1'b1;
            quad_clock_output_pin_ff <= 1'b0;
        end
        else
        begin
            cyc_ff <= nxt_cyc;
            opt_ff <= nxt_opt;
            system_options_two_ff <= nxt_system_options_two;
            bp_ff <= nxt_bp;
            pp_ff <= nxt_pp;
            opt_once_ff <= nxt_once;
            armed_ff <= nxt_armed;
            running_op_ff <= nxt_running_op;
            commit_ff <= nxt_commit;
            op_ff <= nxt_op;
            rdata_ff <= nxt_rdata;
            rd_valid_ff <= bus_rd;
            sys_ff <= nxt_sys;
            irq_prev_ff <= nxt_irq_prev;
            irq_pend_ff <= nxt_irq_pend;
            irq_request_ff <= nxt_irq_req;
            st_ff <= nxt_st;
            dly_cnt_ff <= nxt_dly_cnt;
            running_ff <= nxt_running;
            quad_clock_output_pin_ff <= nxt_quad;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_option_once_lock: assert property (!special_mode && opt_once_ff && $past(opt_once_ff)
        && $past(!special_mode)
        |-> ((opt_ff & eeprom_opt_pkg::OPT_ONCE_MASK) == ($past(opt_ff)
        & eeprom_opt_pkg::OPT_ONCE_MASK)) || $past(!rst_n)) // [RQ1]
        else $error("once-only option field changed after lock");
    a_forced_monitor_sticky: assert property (opt_ff[eeprom_opt_pkg::OPT_FORCED_MONITOR]
        |=> opt_ff[eeprom_opt_pkg::OPT_FORCED_MONITOR] ##1 sys_ff.clock_monitor_on) // [RQ7]
        else $error("forced monitor dropped before reset");
    a_protect_no_clear: assert property (!special_mode && !window_open
        |=> (bp_ff & $past(bp_ff)) == $past(bp_ff)) // [RQ12]
        else $error("protect bit cleared outside window");
    a_both_bits_refused: assert property (wr_pp && !pp_ff[eeprom_opt_pkg::PP_LAT]
        && bus_wdata[eeprom_opt_pkg::PP_LAT] && bus_wdata[eeprom_opt_pkg::PP_HV]
        |=> !pp_ff[eeprom_opt_pkg::PP_LAT] && !pp_ff[eeprom_opt_pkg::PP_HV]) // [RQ16]
        else $error("latch and high voltage set in one first write");
    a_hv_write_ignored: assert property (ee_wr && pp_ff[eeprom_opt_pkg::PP_HV]
        |=> op_ff.index == $past(op_ff.index) && op_ff.data == $past(op_ff.data)) // [RQ17]
        else $error("write during high voltage disturbed operation");
    a_no_op_unarmed: assert property ($rose(pp_ff[eeprom_opt_pkg::PP_HV]) && !$past(armed_ff)
        |-> !running_op_ff ##1 !commit_ff) // [RQ18]
        else $error("operation without latched address");
    a_hv_needs_latch: assert property (pp_ff[eeprom_opt_pkg::PP_HV]
        |-> pp_ff[eeprom_opt_pkg::PP_LAT]) // [RQ27]
        else $error("high voltage without latch");
    a_stop_delay_load: assert property (st_ff == eeprom_opt_pkg::ST_STOPPED
        && sync2_ff[eeprom_opt_pkg::SYNC_WAKE] |=> dly_cnt_ff == ($past(opt_ff[4])
        ? 12'hF9F : 12'h003) ##1 !running_ff) // [RQ6]
        else $error("stop exit delay count wrong");
    a_quad_pin_low: assert property (!system_options_two_ff[eeprom_opt_pkg::SYSTEM_OPTIONS_TWO_QUAD_CLOCK_OUTPUT_ENABLE]
        |=> !quad_clock_output_pin_ff) // [RQ10]
        else $error("quad clock pin driven while disabled");
    c_program_commit: cover property (commit_ff && !op_ff.erase);
    c_erase_commit: cover property (commit_ff && op_ff.erase);
    c_stop_resume: cover property (st_ff == eeprom_opt_pkg::ST_WAKE ##1 running_ff);
endmodule // eeprom_option_ctrl
`default_nettype wire

// [eeprom_program_and_system_options_test.sv]
// Self-checking bench for the option registers and program/erase control.
// Assumes single-chip normal mode; bench drives stop, wake and crystal.
`timescale 1ns/10ps
`default_nettype none
module eeprom_program_and_system_options_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic irq_pin_n = 1'b1;
    logic irq_ack = 1'b0;
    logic stop_enter = 1'b0;
    logic wake_pin = 1'b0;
    logic xtal_clk = 1'b0;
    logic [7:0] rdata_ff;
    logic rd_valid_ff, irq_request_ff, running_ff, quad_ff;
    eeprom_opt_pkg::sys_out_s sys_ff;
    int failures = 0;
    int samples_checked = 0;
    eeprom_option_ctrl i_eeprom_option_ctrl (
        .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .special_mode(1'b0), .single_chip_mode(1'b1),
        .irq_pin_n(irq_pin_n), .irq_ack(irq_ack), .stop_enter(stop_enter),
        .wake_pin(wake_pin), .xtal_clk(xtal_clk), .rdata_ff(rdata_ff),
        .rd_valid_ff(rd_valid_ff), .sys_ff(sys_ff),
        .irq_request_ff(irq_request_ff), .running_ff(running_ff),
        .quad_clock_output_pin_ff(quad_ff));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        chk("rd_valid_ff", {7'h00, rd_valid_ff}, 8'h01);
        chk("rdata_ff", rdata_ff, exp);
    endtask
    // Stray array write during high voltage must leave the operation alone
    task automatic nv(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d,
                      input logic pump);
        wr(16'h103B, ctl);
        wr(a, d);
        wr(16'h103B, ctl | 8'h01);
        repeat (3) @(negedge clk);
        chk("pump_high_voltage", {7'h00, sys_ff.pump_high_voltage}, {7'h00, pump});
        wr(a, 8'h00);
        wr(16'h103B, 8'h00);
        repeat (3) @(negedge clk);
    endtask
    task automatic t_window();
        rd(16'h1039, 8'h00);
        rd(16'h1038, 8'h00);
        rd(16'h1035, 8'h1F);
        rd(16'h103B, 8'h00);
        wr(16'h1039, 8'hFF);
        wr(16'h1038, 8'hFF);
        wr(16'h1035, 8'h00);
        rd(16'h1039, 8'hFF);
        rd(16'h1038, 8'hE0);
        rd(16'h1035, 8'h00);
        rd(16'h1000, 8'h00);
        chk("sys", {sys_ff[14:8], sys_ff.port_g_open_drain}, 8'hFF);
    endtask
    task automatic t_once();
        repeat (70) @(negedge clk);
        wr(16'h1039, 8'h00);
        rd(16'h1039, 8'h37);
        chk("monitor", {7'h00, sys_ff.clock_monitor_on}, 8'h01);
        wr(16'h103B, 8'h03);
        rd(16'h103B, 8'h00);
        wr(16'h103B, 8'h02);
        wr(16'h103B, 8'h03);
        repeat (3) @(negedge clk);
        chk("no_op_pump", {7'h00, sys_ff.pump_high_voltage}, 8'h00);
        wr(16'h103B, 8'h00);
    endtask
    task automatic t_nv();
        nv(8'h06, 16'hFE00, 8'h55, 1'b1);
        rd(16'hFE00, 8'hFF);
        rd(16'hFFFF, 8'hFF);
        nv(8'h02, 16'hFE10, 8'hA5, 1'b1);
        rd(16'hFE10, 8'hA5);
        nv(8'h1A, 16'hFE11, 8'h3C, 1'b1);
        rd(16'hFE11, 8'h3C);
        rd(16'hFE12, 8'hFF);
        nv(8'h0E, 16'hFE15, 8'h00, 1'b1);
        rd(16'hFE10, 8'hFF);
        nv(8'h02, 16'hFE20, 8'h0F, 1'b1);
        nv(8'h02, 16'hFE20, 8'hF0, 1'b1);
        rd(16'hFE20, 8'h00);
    endtask
    task automatic t_protect();
        wr(16'h1035, 8'h11);
        wr(16'h1035, 8'h00);
        rd(16'h1035, 8'h11);
        nv(8'h02, 16'hFE05, 8'h00, 1'b0);
        rd(16'hFE05, 8'hFF);
        nv(8'h02, 16'hFE40, 8'h00, 1'b1);
        rd(16'hFE40, 8'h00);
        nv(8'h02, 16'h103F, 8'h00, 1'b0);
    endtask
    task automatic t_irq();
        irq_pin_n = 1'b0;
        repeat (5) @(negedge clk);
        chk("irq_edge", {7'h00, irq_request_ff}, 8'h01);
        irq_ack = 1'b1;
        @(negedge clk);
        irq_ack = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq_cleared", {7'h00, irq_request_ff}, 8'h00);
    endtask
    task automatic t_stop();
        wr(16'h1039, 8'h00);
        xtal_clk = 1'b1;
        repeat (4) @(negedge clk);
        chk("quad_on", {7'h00, quad_ff}, 8'h01);
        xtal_clk = 1'b0;
        stop_enter = 1'b1;
        @(negedge clk);
        stop_enter = 1'b0;
        wake_pin = 1'b1;
        chk("stopped", {7'h00, running_ff}, 8'h00);
        repeat (3990) @(negedge clk);
        chk("still_waking", {7'h00, running_ff}, 8'h00);
        repeat (20) @(negedge clk);
        chk("resumed", {7'h00, running_ff}, 8'h01);
        wake_pin = 1'b0;
        wr(16'h1039, 8'h08);
        rd(16'h1039, 8'h3F);
        chk("sys_low", sys_ff[7:0], 8'hFE);
        chk("quad_off", {7'h00, quad_ff}, 8'h00);
    endtask
    initial
    begin
        // Cut short a hang; the whole run needs about 4300 cycles
        #200000;
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_window();
        t_once();
        t_nv();
        t_protect();
        t_irq();
        t_stop();
        give_verdict();
    end
endmodule // eeprom_program_and_system_options_test
`default_nettype wire
